// [verilog/standby_defines.svh]
`ifndef STANDBY_DEFINES_SVH
`define STANDBY_DEFINES_SVH
// stop variants on the request input
`define STOP_KIND_NORMAL 1'b0
`define STOP_KIND_LOWV 1'b1
// default oscillation stabilization count, in cycles
`define OSC_STAB_CYCLES 16'h0400
// default converter settling count after resume, in cycles
`define DAC_SETTLE_CYCLES 16'h0010
// run qualifier index of each peripheral
`define RUNQ_WATCH 0
`define RUNQ_WDT 1
`define RUNQ_TIMER_M 2
`define RUNQ_CSERIAL 3
`define RUNQ_ASERIAL 4
`define RUNQ_KEYINT 5
`define RUNQ_LVD 6
`define RUNQ_WIDTH 7
`endif

// [verilog/standby_pkg.sv]
package standby_pkg;
  typedef enum logic [2:0] {
    st_run = 3'b000,
    st_stop = 3'b001,
    st_stab = 3'b010,
    st_settle = 3'b011
  } seq_state_t;
endpackage : standby_pkg

// [verilog/wake_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// two flop synchroniser for a bundle of asynchronous levels
module wake_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : wake_sync
`default_nettype wire

// [verilog/down_counter.sv]
`timescale 1ns/1ps
`default_nettype none
// loadable down counter; done is high while the count is zero and load is low
module down_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic done
);
  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;

  assign nxt_count = load ? load_value :
                     (count_ff != '0) ? count_ff - 1'b1 : count_ff;
  assign done = (count_ff == '0) && !load;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end
endmodule : down_counter
`default_nettype wire

// [verilog/stop_mode_standby_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "standby_defines.svh"
module stop_mode_standby_sequencer
  import standby_pkg::*;
#(
  parameter int NUM_EXT_INT = 8,
  parameter int NUM_PERIPH_INT = 8,
  parameter int CNT_WIDTH = 16,
  parameter logic [15:0] OSC_STAB = `OSC_STAB_CYCLES,
  parameter logic [15:0] DAC_SETTLE = `DAC_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  // request from the cpu: pulse with the stop variant
  input wire logic stop_request,
  input wire logic stop_kind,
  // wake masks from the power save control
  input wire logic maskable_wake_mask,
  input wire logic nmi_pin_wake_mask,
  input wire logic watchdog_nmi_wake_mask,
  // interrupt enable state of the cpu (ei = 1)
  input wire logic cpu_int_enable,
  // wake sources from pins and other domains
  input wire logic nmi_pin,
  input wire logic watchdog_nonmask_interrupt,
  input wire logic [NUM_EXT_INT-1:0] external_interrupt_inputs,
  input wire logic [NUM_EXT_INT-1:0] ext_int_mask_n,
  input wire logic [NUM_PERIPH_INT-1:0] periph_int_req,
  input wire logic [NUM_PERIPH_INT-1:0] periph_int_mask_n,
  // reset sources; they clear the sequencer back to run
  input wire logic reset_pin_req,
  input wire logic watchdog_reset_request,
  input wire logic low_voltage_detector,
  // converter and clock status
  input wire logic adc_running,
  input wire logic adc_result_strobe,
  input wire logic dac_active,
  input wire logic subclock_used,
  // count clock selects of the units that may run on in standby
  input wire logic watch_sel_subclock,
  input wire logic wdt_sel_subclock,
  input wire logic timer_m_sel_subclock,
  input wire logic wdt_sel_internal,
  input wire logic timer_m_sel_internal,
  input wire logic cserial_sel_ext_clock,
  input wire logic aserial_sel_ext_clock,
  // control outputs
  output logic cpu_halt,
  output logic dma_halt,
  output logic intc_halt,
  output logic hold_state,
  output logic rto_hold,
  output logic adc_stop,
  output logic adc_restart,
  output logic adc_result_invalid,
  output logic dac_stop,
  output logic dac_pin_oe,
  output logic regulator_low,
  output logic stop_entry_refused,
  output logic int_ack_allow,
  output logic [`RUNQ_WIDTH-1:0] periph_run
);
  // sequencer state and the context captured at entry
  seq_state_t state_ff, nxt_state;
  logic adc_was_on_ff, dac_was_on_ff, lowv_ff;
  logic adc_drop_ff, nxt_adc_drop;
  // set by a maskable release taken under di, cleared by ei
  logic di_pend_ff;
  logic stab_done, settle_done;
  logic nmi_s, wdt_nmi_s, rst_pin_s, wdt_rst_s, lvd_s;
  logic [NUM_EXT_INT-1:0] ext_s;
  logic [NUM_PERIPH_INT-1:0] periph_s;
  logic [`RUNQ_WIDTH-1:0] nxt_run;

  // pin and foreign-domain sources pass two flops first
  // limitation: a source must hold its level one clock to be seen
  wake_sync #(.WIDTH(5 + NUM_EXT_INT + NUM_PERIPH_INT)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({nmi_pin, watchdog_nonmask_interrupt, reset_pin_req,
               watchdog_reset_request, low_voltage_detector,
               external_interrupt_inputs, periph_int_req}),
    .sync_out({nmi_s, wdt_nmi_s, rst_pin_s, wdt_rst_s, lvd_s,
               ext_s, periph_s})
  );

  // wake decode; masked requests take no part
  wire nmi_wake = (nmi_s && !nmi_pin_wake_mask) ||
                  (wdt_nmi_s && !watchdog_nmi_wake_mask);
  wire maskable_wake = !maskable_wake_mask &&
                       (|(ext_s & ext_int_mask_n) ||
                        |(periph_s & periph_int_mask_n));
  // reset sources take no mask: they always return the chip to run
  wire reset_wake = rst_pin_s || wdt_rst_s || lvd_s;
  // only the interrupt sources start the stabilization wait
  wire any_wake = nmi_wake || maskable_wake;
  // pending unmasked request blocks entry altogether
  wire entry_ok = stop_request && !any_wake && !reset_wake;
  wire in_stop = (state_ff == st_stop);
  wire leaving = in_stop && any_wake;

  // stabilization and settling timers
  down_counter #(.WIDTH(CNT_WIDTH)) u_stab (
    .clk(clk),
    .rst_n(rst_n),
    .load(leaving),
    .load_value(CNT_WIDTH'(OSC_STAB)),
    .done(stab_done)
  );
  // settling starts as stabilization ends; unused with the dac off
  down_counter #(.WIDTH(CNT_WIDTH)) u_settle (
    .clk(clk),
    .rst_n(rst_n),
    .load(state_ff == st_stab && stab_done),
    .load_value(CNT_WIDTH'(DAC_SETTLE)),
    .done(settle_done)
  );

  // sequencer next state
  // reset sources override this in the state flop
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      st_run: begin
        if (entry_ok) nxt_state = st_stop;
      end
      st_stop: begin
        if (any_wake) nxt_state = st_stab;
      end
      st_stab: begin
        if (stab_done) nxt_state = dac_was_on_ff ? st_settle : st_run;
      end
      st_settle: begin
        if (settle_done) nxt_state = st_run;
      end
      default: nxt_state = st_run;
    endcase
  end

  // adc results are dropped from entry until the first (or, in low
  // voltage stop, every) result after release has been flagged
  wire adc_first = adc_result_strobe && state_ff == st_run;
  // entry with the converter on spoils the result it already holds
  wire adc_drop_set = entry_ok && adc_running;
  // after normal stop only the first fresh result is spoilt
  wire adc_drop_clr = adc_first && !lowv_ff;
  // after low voltage stop every result stays suspect until next entry
  wire adc_drop_keep = !entry_ok && lowv_ff && adc_first;
  assign nxt_adc_drop = adc_drop_set ? 1'b1 :
                        adc_drop_clr ? 1'b0 :
                        adc_drop_keep ? 1'b1 : adc_drop_ff;

  // run qualifiers per peripheral while in standby
  // standby spans stop and stabilization; settling already runs the cpu
  wire stby = (nxt_state != st_run) && (nxt_state != st_settle);
  wire lowv_next = entry_ok ? stop_kind : lowv_ff;
  always_comb begin
    nxt_run = '1;
    if (stby) begin
      nxt_run[`RUNQ_WATCH] = subclock_used && watch_sel_subclock;
      // watchdog and timer m also run on the internal oscillator
      nxt_run[`RUNQ_WDT] = wdt_sel_internal ||
                           (subclock_used && wdt_sel_subclock);
      nxt_run[`RUNQ_TIMER_M] = timer_m_sel_internal ||
                               (subclock_used && timer_m_sel_subclock);
      // low-voltage stop halts serial even on external clocks
      nxt_run[`RUNQ_CSERIAL] = cserial_sel_ext_clock &&
                               (lowv_next != `STOP_KIND_LOWV);
      nxt_run[`RUNQ_ASERIAL] = aserial_sel_ext_clock &&
                               (lowv_next != `STOP_KIND_LOWV);
      // key interrupt and the voltage detector stay operable
      nxt_run[`RUNQ_KEYINT] = 1'b1;
      nxt_run[`RUNQ_LVD] = 1'b1;
    end
  end

  // state and captured context; a reset source returns to run
  // rst_n still clears everything at once; sources act on an edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= st_run;
      lowv_ff <= 1'b0;
      adc_was_on_ff <= 1'b0;
      dac_was_on_ff <= 1'b0;
      adc_drop_ff <= 1'b0;
    end else if (reset_wake) begin
      state_ff <= st_run;
      lowv_ff <= 1'b0;
      adc_was_on_ff <= 1'b0;
      dac_was_on_ff <= 1'b0;
      adc_drop_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      lowv_ff <= lowv_next;
      adc_drop_ff <= nxt_adc_drop;
      // converter state is captured once, at the entry edge
      if (entry_ok) begin
        adc_was_on_ff <= adc_running;
        dac_was_on_ff <= dac_active;
      end
    end
  end

  // context at the entry edge comes from the live inputs, since the
  // captured copies only settle one edge later
  function automatic logic at_entry(input logic take, input logic live,
                                    input logic kept);
    at_entry = take ? live : kept;
  endfunction : at_entry

  // converters that were on when standby began
  wire adc_on_now = at_entry(entry_ok, adc_running, adc_was_on_ff);
  wire dac_on_now = at_entry(entry_ok, dac_active, dac_was_on_ff);

  // standby group; halts, state hold and output hold share one level
  wire halt_all = stby && !reset_wake;
  // restart pulses as stabilization ends, before any settling
  wire restart = state_ff == st_stab && stab_done && adc_was_on_ff;
  wire nxt_adc_stop = halt_all && adc_on_now;
  wire nxt_adc_restart = restart && !reset_wake;
  wire nxt_result_invalid = nxt_adc_drop && !reset_wake;
  wire nxt_dac_stop = halt_all && dac_on_now;

  // pin released from entry until settling ends; a reset drives it again
  wire dac_released = (nxt_state != st_run) && dac_on_now;
  wire nxt_dac_oe = reset_wake || !dac_released;
  // regulator follows the variant chosen at entry, not the live input
  wire nxt_reg_low = halt_all && lowv_next;
  wire nxt_refused = stop_request && !entry_ok;

  // a maskable wake under di leaves its request pending; the cpu must
  // not take it before software enables interrupts again
  wire di_wake = leaving && maskable_wake && !cpu_int_enable;
  wire nxt_di_pend = di_wake || (di_pend_ff && !cpu_int_enable);
  wire nxt_ack_allow = cpu_int_enable || !(stby || di_pend_ff);
  wire [`RUNQ_WIDTH-1:0] nxt_periph_run =
    reset_wake ? {`RUNQ_WIDTH{1'b1}} : nxt_run;

  // pending flag; a reset source drops it with the rest of the context
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      di_pend_ff <= 1'b0;
    end else begin
      di_pend_ff <= nxt_di_pend && !reset_wake;
    end
  end

  // every output comes straight from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_halt <= 1'b0;
      dma_halt <= 1'b0;
      intc_halt <= 1'b0;
      hold_state <= 1'b0;
      rto_hold <= 1'b0;
      adc_stop <= 1'b0;
      adc_restart <= 1'b0;
      adc_result_invalid <= 1'b0;
      dac_stop <= 1'b0;
      dac_pin_oe <= 1'b1;
      regulator_low <= 1'b0;
      stop_entry_refused <= 1'b0;
      int_ack_allow <= 1'b1;
      periph_run <= '1;
    end else begin
      cpu_halt <= halt_all;
      dma_halt <= halt_all;
      intc_halt <= halt_all;
      hold_state <= halt_all;
      rto_hold <= halt_all;
      adc_stop <= nxt_adc_stop;
      adc_restart <= nxt_adc_restart;
      adc_result_invalid <= nxt_result_invalid;
      dac_stop <= nxt_dac_stop;
      dac_pin_oe <= nxt_dac_oe;
      regulator_low <= nxt_reg_low;
      stop_entry_refused <= nxt_refused;
      int_ack_allow <= nxt_ack_allow;
      periph_run <= nxt_periph_run;
    end
  end
endmodule : stop_mode_standby_sequencer
`default_nettype wire

// [verif/stop_mode_standby_sequencer_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "standby_defines.svh"
// sees only the ports of the sequencer
module standby_checker_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stop_request,
  input wire logic subclock_used,
  input wire logic nmi_pin,
  input wire logic nmi_pin_wake_mask,
  input wire logic reset_pin_req,
  input wire logic watchdog_reset_request,
  input wire logic low_voltage_detector,
  input wire logic cpu_halt,
  input wire logic dma_halt,
  input wire logic intc_halt,
  input wire logic hold_state,
  input wire logic rto_hold,
  input wire logic adc_stop,
  input wire logic adc_restart,
  input wire logic dac_stop,
  input wire logic dac_pin_oe,
  input wire logic regulator_low,
  input wire logic stop_entry_refused,
  input wire logic [`RUNQ_WIDTH-1:0] periph_run
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_halt_cause: assert property ($rose(cpu_halt) |-> $past(stop_request))
    else $error("halt rose without a stop request");
  a_halt_group: assert property (cpu_halt |-> dma_halt && intc_halt &&
    hold_state && rto_hold) else $error("halt group split");
  a_refuse_pulse: assert property (stop_entry_refused |-> !cpu_halt &&
    $past(stop_request) ##1 !stop_entry_refused) else $error("bad refusal");
  a_dac_hiz: assert property (dac_stop |-> !dac_pin_oe)
    else $error("converter pin driven while stopped");
  a_adc_halted: assert property (adc_stop |-> cpu_halt)
    else $error("converter stopped outside standby");
  a_restart_once: assert property (adc_restart |=> !adc_restart)
    else $error("restart longer than one cycle");
  a_reg_normal: assert property (regulator_low |-> cpu_halt)
    else $error("regulator low outside standby");
  // the synchroniser and the stabilization count keep the halt up for long
  a_stab_wait: assert property ($rose(nmi_pin) && cpu_halt &&
    !nmi_pin_wake_mask && !reset_pin_req && !watchdog_reset_request &&
    !low_voltage_detector |=> cpu_halt [*5]) else $error("early release");
  a_watch_stop: assert property (cpu_halt && $past(cpu_halt) &&
    !$past(subclock_used) |-> !periph_run[`RUNQ_WATCH])
    else $error("watch timer runs without subclock");
endmodule : standby_checker_sva
bind stop_mode_standby_sequencer standby_checker_sva u_sva (.*);
`default_nettype wire

// [verif/wake_source_model.sv]
`timescale 1ns/1ps
`default_nettype none
// far side: a non-maskable source and an external serial clock source
module wake_source_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic lv_stop_soon,
  output logic nmi_pin,
  output logic ext_serial_clk
);
  logic [1:0] hold_ff;
  // three cycle level: long enough for a two flop synchroniser to see it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hold_ff <= 2'h0;
    else if (fire) hold_ff <= 2'h3;
    else if (hold_ff != 2'h0) hold_ff <= hold_ff - 2'h1;
  end
  assign nmi_pin = hold_ff != 2'h0;
  // clock stands still before low voltage stop, the channel cannot take it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ext_serial_clk <= 1'b0;
    else ext_serial_clk <= lv_stop_soon ? 1'b0 : ~ext_serial_clk;
  end
endmodule : wake_source_model
`default_nettype wire

// [verif/stop_mode_standby_sequencer_test.sv]
`timescale 1ns/1ps
`default_nettype none
module stop_mode_standby_sequencer_test;
  logic clk = 0, rst_n = 0, stop_request = 0, stop_kind = 0, fire = 0;
  logic maskable_wake_mask = 0, nmi_pin_wake_mask = 0;
  logic watchdog_nmi_wake_mask = 0, cpu_int_enable = 1, lv_stop_soon = 0;
  logic watchdog_nonmask_interrupt = 0, reset_pin_req = 0;
  logic watchdog_reset_request = 0, low_voltage_detector = 0;
  logic adc_running = 0, adc_result_strobe = 0, dac_active = 0;
  logic subclock_used = 0, watch_sel_subclock = 0, wdt_sel_subclock = 0;
  logic timer_m_sel_subclock = 0, wdt_sel_internal = 0;
  logic timer_m_sel_internal = 0, cserial_sel_ext_clock = 0;
  logic aserial_sel_ext_clock = 0;
  logic [7:0] external_interrupt_inputs = 8'h00, ext_int_mask_n = 8'hff;
  logic [7:0] periph_int_req = 8'h00, periph_int_mask_n = 8'hff;
  logic nmi_pin, ext_serial_clk, cpu_halt, dma_halt, intc_halt, hold_state;
  logic rto_hold, adc_stop, adc_restart, adc_result_invalid, dac_stop;
  logic dac_pin_oe, regulator_low, stop_entry_refused, int_ack_allow;
  logic [6:0] periph_run;
  int num_errors = 0, checked = 0, waited;
  // short counts keep the run brief
  stop_mode_standby_sequencer #(.OSC_STAB(16'h0004), .DAC_SETTLE(16'h0002))
    dut (.*);
  wake_source_model far_end (.*);
  always #50 clk = ~clk;
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // bounded wait for the halt level; leaves the cycle count in waited
  task automatic wait_halt(input logic v);
    waited = 0;
    while (cpu_halt !== v && waited < 200) begin
      @(posedge clk); #1; waited++;
    end
    if (waited == 200) begin num_errors++; give_verdict(); end
  endtask : wait_halt
  task automatic req(input logic kind);
    @(posedge clk); stop_request <= 1'b1; stop_kind <= kind;
    @(posedge clk); stop_request <= 1'b0; #1;
  endtask : req
  task automatic strobe2();
    repeat (2) begin
      @(posedge clk); adc_result_strobe <= 1'b1;
      @(posedge clk); adc_result_strobe <= 1'b0;
    end
    repeat (2) @(posedge clk); #1;
  endtask : strobe2
  task automatic t_normal();
    @(posedge clk); adc_running <= 1; dac_active <= 1; subclock_used <= 0;
    req(0); wait_halt(1);
    check("ctl", {dma_halt, intc_halt, hold_state, rto_hold, adc_stop,
      dac_stop, dac_pin_oe, regulator_low}, 8'hfc);
    check("inv", adc_result_invalid, 1);
    check("watch", periph_run[0], 0);
    @(posedge clk); fire <= 1; @(posedge clk); fire <= 0;
    wait_halt(0);
    check("inv_wake", adc_result_invalid, 1);
    check("restart", adc_restart, 1);
    repeat (10) @(posedge clk); #1;
    check("dac_oe", {dac_stop, dac_pin_oe}, 1);
    strobe2(); check("inv_2nd", adc_result_invalid, 0);
    $display("normal stop done");
  endtask : t_normal
  task automatic t_lowv();
    @(posedge clk); cpu_int_enable <= 0; subclock_used <= 1;
    watch_sel_subclock <= 1; lv_stop_soon <= 1; cserial_sel_ext_clock <= 1;
    aserial_sel_ext_clock <= 1; wdt_sel_internal <= 1;
    req(1); wait_halt(1); #1;
    check("reg", regulator_low, 1);
    check("watch", periph_run[0], 1);
    check("sclk", ext_serial_clk, 0);
    check("runq", periph_run, 8'h63);
    @(posedge clk); external_interrupt_inputs <= 8'h04;
    wait_halt(0);
    check("reg_off", regulator_low, 0);
    check("ack", int_ack_allow, 0);
    check("restart_lv", adc_restart, 1);
    strobe2(); check("inv_lv", adc_result_invalid, 1);
    @(posedge clk); external_interrupt_inputs <= 8'h00; cpu_int_enable <= 1;
    lv_stop_soon <= 0; subclock_used <= 0;
    repeat (6) @(posedge clk); #1;
    check("ack_ei", int_ack_allow, 1);
    $display("low voltage stop done");
  endtask : t_lowv
  task automatic t_masked();
    @(posedge clk); maskable_wake_mask <= 1; nmi_pin_wake_mask <= 1;
    watchdog_nmi_wake_mask <= 1; ext_int_mask_n <= 0; periph_int_mask_n <= 0;
    req(0); wait_halt(1);
    @(posedge clk); fire <= 1; watchdog_nonmask_interrupt <= 1;
    external_interrupt_inputs <= 8'hff; periph_int_req <= 8'hff;
    @(posedge clk); fire <= 0; repeat (20) @(posedge clk); #1;
    check("masked", cpu_halt, 1);
    @(posedge clk); low_voltage_detector <= 1; wait_halt(0);
    @(posedge clk); low_voltage_detector <= 0; watchdog_nonmask_interrupt <= 0;
    external_interrupt_inputs <= 0; periph_int_req <= 0;
    maskable_wake_mask <= 0; nmi_pin_wake_mask <= 0;
    watchdog_nmi_wake_mask <= 0; ext_int_mask_n <= 8'hff;
    periph_int_mask_n <= 8'hff; repeat (6) @(posedge clk);
    $display("masked wake done");
  endtask : t_masked
  task automatic t_refuse();
    logic seen;
    seen = 0;
    @(posedge clk); periph_int_req <= 8'h02; repeat (4) @(posedge clk);
    req(0);
    repeat (3) begin seen |= stop_entry_refused; @(posedge clk); #1; end
    check("refused", {seen, cpu_halt}, 2);
    @(posedge clk); periph_int_req <= 8'h00; repeat (6) @(posedge clk);
    $display("refusal done");
  endtask : t_refuse
  // every release source in turn; interrupts wait out stabilization
  task automatic t_sources();
    for (int i = 0; i < 7; i++) begin
      req(0); wait_halt(1);
      @(posedge clk);
      case (i)
        0: fire <= 1;
        1: watchdog_nonmask_interrupt <= 1;
        2: external_interrupt_inputs <= 8'h01;
        3: periph_int_req <= 8'h80;
        4: reset_pin_req <= 1;
        5: watchdog_reset_request <= 1;
        default: low_voltage_detector <= 1;
      endcase
      wait_halt(0);
      if (i < 4) check("stab", waited >= 6, 1);
      @(posedge clk);
      fire <= 0; watchdog_nonmask_interrupt <= 0; reset_pin_req <= 0;
      external_interrupt_inputs <= 0; periph_int_req <= 0;
      watchdog_reset_request <= 0; low_voltage_detector <= 0;
      repeat (6) @(posedge clk);
    end
    $display("release sources done");
  endtask : t_sources
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    t_normal(); t_lowv(); t_masked(); t_refuse(); t_sources();
    give_verdict();
  end
endmodule : stop_mode_standby_sequencer_test
`default_nettype wire
